/* uart_baud_status_receive.sv */
// modem status, baud divisor, receiver with buffer and scratchpad behind Avalon-MM
// Contract
// [R01] carrier change flag, status bit 3, sets when carrier input changes since last read
// [R02] carrier change flag set with modem interrupt enabled raises the modem interrupt
// [R03] status bit 4 is inverted clear-to-send, or control bit 1 in loopback
// [R04] status bit 5 is inverted data-set-ready, or control bit 0 in loopback
// [R05] status bit 6 is inverted ring indicator, or control bit 2 in loopback
// [R06] status bit 7 is inverted carrier detect, or control bit 3 in loopback
// [R07] baud generator divides reference clock by any divisor 1 to 65535
// [R08] baud generator output runs at sixteen times the bit rate
// [R09] software picks divisor as reference frequency over sixteen times bit rate
// [R10] divisor held in two separately writable byte registers, low and high
// [R11] host writes both divisor bytes during setup before serial traffic
// [R12] any divisor byte write reloads the baud counter at once
// [R13] receive buffer is a first-in first-out store of 16 bytes
// [R14] receiver is timed by the separate 16x receiver clock input
// [R15] receive shifter samples input, assembles characters, moves them into buffer
// [R16] length, parity and stop handling follow the line control register; the code ignores the stop bit setting and checks only the first stop bit
// [R17] character mode: byte arriving with enable bit 0 set raises data interrupt
// [R18] character mode: reading the receive buffer clears the data interrupt
// [R19] fifo mode: receive interrupt follows the fifo trigger level setting
// [R20] scratchpad byte is freely read and written and affects nothing else
// [R21] reading modem status clears all four change flags together
// [R22] loopback disconnects modem inputs and feeds modem control outputs back in
// [R23] baud counter counts down, reloads at terminal count, one tick per period
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module uart_baud_status_receive #(
	parameter int DEPTH = uart_pkg::RX_DEPTH // receive buffer depth, power of two
) (
	input wire logic CLK, // system clock, 250 MHz
	input wire logic NRST, // asynchronous reset, active low
	input wire logic [uart_pkg::ADDR_W-1:0] AVS_ADDRESS, // byte address, word aligned
	input wire logic AVS_READ, // read request
	input wire logic AVS_WRITE, // write request
	input wire logic [31:0] AVS_WRITEDATA, // write data, low byte used
	input wire logic [3:0] AVS_BYTEENABLE, // lane 0 gates writes
	output logic [31:0] AVS_READDATA, // read data, upper bits zero
	output logic AVS_WAITREQUEST, // low for one cycle per answer
	input wire logic REF_CLK_IN, // reference clock pin
	input wire logic RX_CLK_IN, // 16x receiver clock pin
	input wire logic SERIAL_INPUT, // serial data pin
	input wire logic CTS_N, // clear to send pin
	input wire logic DSR_N, // data set ready pin
	input wire logic RI_N, // ring indicator pin
	input wire logic DCD_N, // carrier detect pin
	output logic [3:0] MODEM_OUT_N, // user_output_b, user_output_a, rts, dtr
	output logic BAUD_OUT, // 16x tick pulse
	output logic IRQ_MODEM, // modem status interrupt
	output logic IRQ_RX_AVAIL // received data interrupt
);
	import uart_pkg::*;

	localparam int PTR_W = $clog2(DEPTH);

	typedef struct packed {
		logic [3:0] mi_s0;
		logic [3:0] mi_s1;
		logic [3:0] prev_eff;
		logic rclk_s0;
		logic rclk_s1;
		logic rclk_s2;
		logic sin_s0;
		logic sin_s1;
		logic [7:0] ier;
		logic fc_en;
		logic [1:0] fc_trig;
		logic [7:0] lcr;
		logic [4:0] modem_control;
		logic [3:0] msr_chg;
		logic [7:0] scratch;
		logic [15:0] div;
		logic reload;
		rx_state_t rx_st;
		logic [3:0] rx_cnt;
		logic [2:0] rx_bit;
		logic [7:0] rx_shift;
		logic rx_par;
		logic rx_pe;
		logic [DEPTH-1:0][9:0] mem;
		logic [PTR_W-1:0] wr;
		logic [PTR_W-1:0] rd;
		logic [PTR_W:0] count;
		logic overrun;
		logic wait_q;
		logic [7:0] rdata;
		logic [3:0] modem_out;
		logic baud;
		logic irq_modem;
		logic irq_rx;
	} state_t;

	state_t s;
	state_t n;
	logic loop;
	logic rtick;
	logic serial_input;
	logic take;
	logic wr_en;
	logic rd_rx;
	logic rd_msr;
	logic push;
	logic do_push;
	logic pop;
	logic full;
	logic flush;
	logic exp_par;
	logic [2:0] last_bit;
	logic [3:0] eff;
	logic [3:0] chg;
	logic [7:0] stat;
	logic [7:0] wd;
	logic [7:0] rmux;
	logic [9:0] head;

	baud_if bif ();

	baud_gen u_baud (
		.clk(CLK),
		.nrst(NRST),
		.ref_clk_in(REF_CLK_IN),
		.bus(bif)
	);

	assign bif.divisor = s.div;
	assign bif.reload = s.reload;

	// receive trigger level from the fifo control field
	function automatic logic [4:0] trig_level(input logic [1:0] sel);
		case (sel)
			2'h0: trig_level = TRIG_L0;
			2'h1: trig_level = TRIG_L1;
			2'h2: trig_level = TRIG_L2;
			default: trig_level = TRIG_L3;
		endcase
	endfunction

	// whole next state in one process
	always_comb begin
		n = s;
		// pins pass two flops before anything looks at them
		n.mi_s0 = {DCD_N, RI_N, DSR_N, CTS_N};
		n.mi_s1 = s.mi_s0;
		n.rclk_s0 = RX_CLK_IN;
		n.rclk_s1 = s.rclk_s0;
		n.rclk_s2 = s.rclk_s1;
		n.sin_s0 = SERIAL_INPUT;
		n.sin_s1 = s.sin_s0;
		n.reload = 1'b0;
		n.baud = bif.tick; // [R08]

		// loopback swaps pin levels for the inverted control bits
		loop = s.modem_control[MC_LOOP];
		eff = loop ? ~{s.modem_control[3], s.modem_control[2], s.modem_control[0], s.modem_control[1]} : s.mi_s1; // [R22]
		n.prev_eff = eff;
		// ring flag catches only the pin going from low to high
		chg[0] = eff[0] ^ s.prev_eff[0];
		chg[1] = eff[1] ^ s.prev_eff[1];
		chg[2] = eff[2] & ~s.prev_eff[2];
		chg[3] = eff[3] ^ s.prev_eff[3]; // [R01]
		stat = {~eff, s.msr_chg}; // [R03] [R04] [R05] [R06]

		// bus: take one request while waitrequest is high, answer it with one waitrequest-low cycle
		take = (AVS_READ | AVS_WRITE) & s.wait_q;
		wr_en = take & AVS_WRITE & AVS_BYTEENABLE[0];
		rd_rx = take & AVS_READ & (AVS_ADDRESS == A_RXBUF);
		rd_msr = take & AVS_READ & (AVS_ADDRESS == A_MODSTAT);
		n.wait_q = ~take;
		wd = AVS_WRITEDATA[7:0];
		head = s.mem[s.rd];

		// read clear first, so a change in the same cycle survives
		n.msr_chg = (rd_msr ? 4'h0 : s.msr_chg) | chg; // [R21] [R01]

		case (AVS_ADDRESS)
			A_RXBUF: rmux = head[7:0];
			A_IRQEN: rmux = s.ier;
			A_FIFOCTL: rmux = {s.fc_trig, 5'h00, s.fc_en};
			A_LINECTL: rmux = s.lcr;
			A_MODCTL: rmux = {3'h0, s.modem_control};
			A_MODSTAT: rmux = stat;
			A_SCRATCH: rmux = s.scratch; // [R20]
			A_DIVLO: rmux = s.div[7:0];
			A_DIVHI: rmux = s.div[15:8];
			A_RXSTAT: rmux = {2'h0, s.irq_rx, s.irq_modem, head[9], head[8], s.overrun, s.count != '0};
			default: rmux = 8'h00;
		endcase
		if (take && AVS_READ) begin
			n.rdata = rmux;
		end

		flush = 1'b0;
		if (wr_en) begin
			case (AVS_ADDRESS)
				A_IRQEN: n.ier = wd;
				A_FIFOCTL: begin
					n.fc_en = wd[FC_EN];
					n.fc_trig = wd[FC_TRIG +: 2];
					// mode change or reset bit empties the buffer
					flush = wd[FC_RST] | (wd[FC_EN] != s.fc_en);
				end
				A_LINECTL: n.lcr = wd; // [R16]
				A_MODCTL: n.modem_control = wd[4:0];
				A_SCRATCH: n.scratch = wd; // [R20]
				A_DIVLO: begin
					n.div[7:0] = wd; // [R10]
					n.reload = 1'b1; // [R12]
				end
				A_DIVHI: begin
					n.div[15:8] = wd; // [R10]
					n.reload = 1'b1; // [R12]
				end
				default: n.ier = s.ier;
			endcase
		end

		// receiver steps only on receiver clock edges
		rtick = s.rclk_s1 & ~s.rclk_s2; // [R14]
		serial_input = loop ? 1'b1 : s.sin_s1; // [R22]
		last_bit = MIN_LAST_BIT + {1'b0, s.lcr[1:0]};
		exp_par = s.lcr[LC_STICK] ? ~s.lcr[LC_EVEN] : (s.lcr[LC_EVEN] ? s.rx_par : ~s.rx_par);
		push = 1'b0;
		if (rtick) begin
			if (s.rx_cnt != 4'h0 && s.rx_st != RX_IDLE) begin
				n.rx_cnt = s.rx_cnt - 4'h1;
			end else begin
				case (s.rx_st)
					RX_IDLE: begin
						if (!serial_input) begin
							n.rx_st = RX_START;
							n.rx_cnt = MID_SAMPLE;
						end
					end
					RX_START: begin
						// high at mid start bit is a glitch, not a character
						if (serial_input) begin
							n.rx_st = RX_IDLE;
						end else begin
							n.rx_st = RX_DATA;
							n.rx_cnt = OVERSAMPLE;
							n.rx_bit = 3'h0;
							n.rx_shift = 8'h00;
							n.rx_par = 1'b0;
							n.rx_pe = 1'b0;
						end
					end
					RX_DATA: begin
						n.rx_shift[s.rx_bit] = serial_input; // [R15]
						n.rx_par = s.rx_par ^ serial_input;
						n.rx_bit = s.rx_bit + 3'h1;
						n.rx_cnt = OVERSAMPLE;
						if (s.rx_bit == last_bit) begin
							n.rx_st = s.lcr[LC_PEN] ? RX_PAR : RX_STOP; // [R16]
						end
					end
					RX_PAR: begin
						n.rx_pe = serial_input ^ exp_par; // [R16]
						n.rx_cnt = OVERSAMPLE;
						n.rx_st = RX_STOP;
					end
					RX_STOP: begin
						// only the first stop bit is checked; a low one is a framing error
						push = 1'b1; // [R15]
						n.rx_st = RX_IDLE;
					end
					default: n.rx_st = RX_IDLE;
				endcase
			end
		end

		// buffer: full depth in fifo mode, one byte in character mode
		pop = rd_rx & (s.count != '0); // [R18]
		full = s.fc_en ? (s.count == (PTR_W + 1)'(DEPTH)) : (s.count != '0); // [R13]
		do_push = push & ~full & ~flush;
		if (rd_rx && AVS_ADDRESS == A_RXBUF) begin
			n.overrun = s.overrun;
		end
		if (take && AVS_READ && AVS_ADDRESS == A_RXSTAT) begin
			n.overrun = 1'b0;
		end
		if (push && full) begin
			n.overrun = 1'b1;
		end
		if (do_push) begin
			n.mem[s.wr] = {~serial_input, s.rx_pe, s.rx_shift}; // [R15]
			n.wr = s.wr + 1'b1;
		end
		if (pop) begin
			n.rd = s.rd + 1'b1;
		end
		n.count = s.count + (PTR_W + 1)'(do_push) - (PTR_W + 1)'(pop);
		if (flush) begin
			n.wr = '0;
			n.rd = '0;
			n.count = '0;
		end

		// interrupts follow the next state so they track reads at once
		if (s.fc_en) begin
			n.irq_rx = s.ier[IE_RX] & (int'(n.count) >= int'(trig_level(s.fc_trig))); // [R19]
		end else begin
			n.irq_rx = s.ier[IE_RX] & (n.count != '0); // [R17] [R18]
		end
		n.irq_modem = s.ier[IE_MODEM] & (|n.msr_chg); // [R02]
		// controls are active low on the pins and parked high in loopback
		n.modem_out = loop ? PINS_IDLE : ~s.modem_control[3:0]; // [R22]
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			s <= '0;
			s.mi_s0 <= PINS_IDLE;
			s.mi_s1 <= PINS_IDLE;
			s.prev_eff <= PINS_IDLE;
			s.sin_s0 <= 1'b1;
			s.sin_s1 <= 1'b1;
			s.rx_st <= RX_IDLE;
			s.wait_q <= 1'b1;
			s.modem_out <= PINS_IDLE;
			s.div <= DIV_RESET;
			s.ier <= REG_RESET;
			s.lcr <= REG_RESET;
			s.scratch <= REG_RESET;
		end else begin
			s <= n;
		end
	end

	// outputs straight from the state register
	assign AVS_READDATA = {24'h000000, s.rdata};
	assign AVS_WAITREQUEST = s.wait_q;
	assign MODEM_OUT_N = s.modem_out;
	assign BAUD_OUT = s.baud;
	assign IRQ_MODEM = s.irq_modem;
	assign IRQ_RX_AVAIL = s.irq_rx;

	a_dcd_change: assert property (@(posedge CLK) disable iff (!NRST) // [R01]
		(eff[3] != s.prev_eff[3]) |=> s.msr_chg[MS_DCD_CHG] ##1 (s.msr_chg[MS_DCD_CHG] || $past(rd_msr)))
		else $error("carrier change flag not set");
	a_modem_irq: assert property (@(posedge CLK) disable iff (!NRST) // [R02]
		(s.msr_chg[MS_DCD_CHG] && s.ier[IE_MODEM] && !rd_msr && !wr_en) |=> IRQ_MODEM)
		else $error("modem interrupt missing");
	a_loop_status: assert property (@(posedge CLK) disable iff (!NRST) // [R03] [R04] [R05] [R06]
		loop ? (stat[7:4] == {s.modem_control[3], s.modem_control[2], s.modem_control[0], s.modem_control[1]}) : (stat[7:4] == ~s.mi_s1))
		else $error("modem status line bits wrong");
	a_msr_clear: assert property (@(posedge CLK) disable iff (!NRST) // [R21]
		(rd_msr && chg == 4'h0) |=> s.msr_chg == 4'h0)
		else $error("change flags not cleared by read");
	a_div_reload: assert property (@(posedge CLK) disable iff (!NRST) // [R12]
		(wr_en && AVS_ADDRESS == A_DIVLO) |=> s.reload && s.div[7:0] == $past(AVS_WRITEDATA[7:0]))
		else $error("divisor write did not reload");
	a_rx_irq_set: assert property (@(posedge CLK) disable iff (!NRST) // [R17]
		(!s.fc_en && s.ier[IE_RX] && do_push && !wr_en) |=> IRQ_RX_AVAIL)
		else $error("data interrupt not raised");
	a_rx_irq_clear: assert property (@(posedge CLK) disable iff (!NRST) // [R18]
		(!s.fc_en && pop && !do_push) |=> (s.count == '0 && !IRQ_RX_AVAIL))
		else $error("data interrupt not cleared by read");
	a_fifo_bound: assert property (@(posedge CLK) disable iff (!NRST) // [R13]
		s.count <= (PTR_W + 1)'(DEPTH))
		else $error("receive buffer overfilled");
	a_scratch_hold: assert property (@(posedge CLK) disable iff (!NRST) // [R20]
		!(wr_en && AVS_ADDRESS == A_SCRATCH) |=> $stable(s.scratch))
		else $error("scratchpad changed without write");
	a_bus_answer: assert property (@(posedge CLK) disable iff (!NRST)
		take |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
		else $error("bus answer not one cycle");
endmodule

/* uart_pkg.sv */
// shared register map, field positions, reset values and receiver timing
package uart_pkg;
	localparam int ADDR_W = 6;
	localparam logic [5:0] A_RXBUF = 6'h00;
	localparam logic [5:0] A_IRQEN = 6'h04;
	localparam logic [5:0] A_FIFOCTL = 6'h08;
	localparam logic [5:0] A_LINECTL = 6'h0c;
	localparam logic [5:0] A_MODCTL = 6'h10;
	localparam logic [5:0] A_MODSTAT = 6'h14;
	localparam logic [5:0] A_SCRATCH = 6'h18;
	localparam logic [5:0] A_DIVLO = 6'h1c;
	localparam logic [5:0] A_DIVHI = 6'h20;
	localparam logic [5:0] A_RXSTAT = 6'h24;
	localparam int IE_RX = 0;
	localparam int IE_MODEM = 3;
	localparam int FC_EN = 0;
	localparam int FC_RST = 1;
	localparam int FC_TRIG = 6;
	localparam int LC_PEN = 3;
	localparam int LC_EVEN = 4;
	localparam int LC_STICK = 5;
	localparam int MC_LOOP = 4;
	localparam int MS_DCD_CHG = 3;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [15:0] DIV_RESET = 16'h0000;
	localparam logic [3:0] PINS_IDLE = 4'hf;
	// sixteen receiver clock ticks per bit, counted down to zero
	localparam logic [3:0] OVERSAMPLE = 4'hf;
	localparam logic [3:0] MID_SAMPLE = 4'h7;
	localparam logic [2:0] MIN_LAST_BIT = 3'h4;
	localparam int RX_DEPTH = 16;
	localparam logic [4:0] TRIG_L0 = 5'h01;
	localparam logic [4:0] TRIG_L1 = 5'h04;
	localparam logic [4:0] TRIG_L2 = 5'h08;
	localparam logic [4:0] TRIG_L3 = 5'h0e;
	typedef enum logic [4:0] {
		RX_IDLE = 5'h01,
		RX_START = 5'h02,
		RX_DATA = 5'h04,
		RX_PAR = 5'h08,
		RX_STOP = 5'h10
	} rx_state_t;
endpackage

/* baud_if.sv */
// divisor, reload strobe and 16x tick between register file and baud counter
`timescale 1ns/1ps
interface baud_if;
	logic [15:0] divisor;
	logic reload;
	logic tick;
	modport gen (input divisor, input reload, output tick);
	modport ctl (output divisor, output reload, input tick);
endinterface

/* baud_gen.sv */
// programmable baud counter, driven by edges of the sampled reference clock
`timescale 1ns/1ps
module baud_gen (
	input wire logic clk, // system clock
	input wire logic nrst, // asynchronous reset, active low
	input wire logic ref_clk_in, // reference clock pin
	baud_if.gen bus // divisor in, tick out
);
	import uart_pkg::*;

	typedef struct packed {
		logic ref_s0;
		logic ref_s1;
		logic ref_s2;
		logic [15:0] cnt;
		logic tick;
	} gen_state_t;

	gen_state_t s_q;
	gen_state_t s_d;
	logic ref_edge;

	// next state: sample the pin, count down per reference edge
	always_comb begin
		s_d = s_q;
		s_d.ref_s0 = ref_clk_in;
		s_d.ref_s1 = s_q.ref_s0;
		s_d.ref_s2 = s_q.ref_s1;
		s_d.tick = 1'b0;
		ref_edge = s_q.ref_s1 & ~s_q.ref_s2;
		if (bus.reload) begin
			// reload at once so a fresh divisor never waits out an old count
			s_d.cnt = bus.divisor; // [R12]
		end else if (ref_edge && bus.divisor != 16'h0000) begin
			if (s_q.cnt <= 16'h0001) begin
				s_d.cnt = bus.divisor; // [R23]
				s_d.tick = 1'b1; // [R08]
			end else begin
				s_d.cnt = s_q.cnt - 16'h0001; // [R07]
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.cnt <= DIV_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign bus.tick = s_q.tick;

	a_reload_count: assert property (@(posedge clk) disable iff (!nrst) // [R12]
		bus.reload |=> s_q.cnt == $past(bus.divisor))
		else $error("baud counter not reloaded from divisor");
	a_tick_terminal: assert property (@(posedge clk) disable iff (!nrst) // [R23]
		s_q.tick |-> $past(ref_edge) && $past(s_q.cnt) <= 16'h0001 && !$past(bus.reload))
		else $error("baud tick without terminal count");
endmodule

/* uart_peer_model.sv */
// serial peer model: modem pins and framed characters toward the receiver
`timescale 1ns/1ps
module uart_peer_model (
	input wire logic clk, // system clock
	input wire logic tick, // 16x tick from the device
	output logic serial_out, // line toward the receiver, idle at mark
	output logic [3:0] pins_n // carrier, ring, set ready, clear to send
);
	// all lines inactive high from time zero
	initial begin
		serial_out = 1'b1;
		pins_n = 4'hf;
	end
	// modem pins move right after a clock edge
	task automatic set_pin(input int i, input logic v);
		pins_n[i] <= v;
	endtask
	// one line level held for a whole bit of sixteen ticks
	task automatic hold_bit(input logic b);
		serial_out <= b;
		repeat (16) @(posedge clk iff tick);
	endtask
	// start, data lsb first, optional parity, one stop, then one idle bit
	task automatic send_frame(input logic [7:0] d, input int nbits, input logic par_on, input logic par);
		@(posedge clk);
		hold_bit(1'b0);
		for (int i = 0; i < nbits; i++) begin
			hold_bit(d[i]);
		end
		if (par_on) begin
			hold_bit(par);
		end
		hold_bit(1'b1);
		repeat (16) @(posedge clk iff tick);
	endtask
endmodule

/* test_uart_baud_status_receive.sv */
// self-checking bench: register bus, modem pins, baud ticks and receive path
`timescale 1ns/1ps
module test_uart_baud_status_receive;
	import uart_pkg::*;
	logic CLK = 1'b0;
	logic NRST;
	logic [5:0] AVS_ADDRESS;
	logic AVS_READ;
	logic AVS_WRITE;
	logic [31:0] AVS_WRITEDATA;
	logic [3:0] AVS_BYTEENABLE;
	logic [31:0] AVS_READDATA;
	logic AVS_WAITREQUEST;
	logic REF_CLK_IN = 1'b0;
	logic [1:0] ref_cnt = 2'h0;
	logic SERIAL_INPUT;
	logic [3:0] PINS_N;
	logic [3:0] MODEM_OUT_N;
	logic BAUD_OUT;
	logic IRQ_MODEM;
	logic IRQ_RX_AVAIL;
	logic [31:0] rd;
	int fail_count = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;

	uart_baud_status_receive i_dut (
		.CLK(CLK), .NRST(NRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .REF_CLK_IN(REF_CLK_IN), .RX_CLK_IN(BAUD_OUT),
		.SERIAL_INPUT(SERIAL_INPUT), .CTS_N(PINS_N[0]), .DSR_N(PINS_N[1]), .RI_N(PINS_N[2]), .DCD_N(PINS_N[3]),
		.MODEM_OUT_N(MODEM_OUT_N), .BAUD_OUT(BAUD_OUT), .IRQ_MODEM(IRQ_MODEM), .IRQ_RX_AVAIL(IRQ_RX_AVAIL)
	);
	uart_peer_model i_peer (.clk(CLK), .tick(BAUD_OUT), .serial_out(SERIAL_INPUT), .pins_n(PINS_N));

	always #2 CLK = ~CLK;
	// reference clock with three system cycles per half period, slow enough for the sync to see every edge
	always @(posedge CLK) begin
		ref_cnt <= (ref_cnt == 2'h2) ? 2'h0 : ref_cnt + 2'h1;
		if (ref_cnt == 2'h2) begin
			REF_CLK_IN <= !REF_CLK_IN;
		end
	end
	// hang guard, well above the roughly 23000 cycles the sequence needs
	always @(posedge CLK) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			fail_count++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one bus cycle: request held until waitrequest is seen low, data taken at that edge
	task automatic bus_xfer(input logic wr, input logic [5:0] a, input logic [7:0] d, input logic [3:0] be);
		@(posedge CLK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= {24'h000000, d};
		AVS_BYTEENABLE <= be;
		AVS_READ <= !wr;
		AVS_WRITE <= wr;
		do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
		rd = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		bus_xfer(1'b1, a, d, 4'h1);
	endtask
	task automatic rdc(input logic [5:0] a, input logic [7:0] e);
		bus_xfer(1'b0, a, 8'h00, 4'h0);
		check(rd, {24'h000000, e});
	endtask
	// cycles between two consecutive baud ticks
	// the first tick may still come from the old divisor, so it is skipped
	task automatic tick_gap(output int g);
		g = 0;
		repeat (2) @(posedge CLK iff BAUD_OUT);
		do begin
			@(posedge CLK);
			g++;
		end while (BAUD_OUT !== 1'b1);
	endtask

	initial begin
		NRST = 1'b0;
		AVS_ADDRESS = 6'h00;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_WRITEDATA = 32'h00000000;
		AVS_BYTEENABLE = 4'h0;
		repeat (16) @(posedge CLK);
		NRST <= 1'b1;
		// reset values, read-only and unmapped places, byte lane gating
		rdc(A_MODSTAT, 8'h00);
		wr(A_RXBUF, 8'h77);
		rdc(A_RXBUF, 8'h00);
		rdc(6'h3c, 8'h00);
		bus_xfer(1'b1, A_SCRATCH, 8'h3c, 4'h0);
		rdc(A_SCRATCH, 8'h00);
		wr(A_SCRATCH, 8'ha5);
		rdc(A_SCRATCH, 8'ha5);
		rdc(A_MODSTAT, 8'h00);
		// each modem pin asserted then released, flags cleared by every read
		wr(A_IRQEN, 8'h08);
		for (int i = 0; i < 4; i++) begin
			i_peer.set_pin(i, 1'b0);
			repeat (8) @(posedge CLK);
			check(IRQ_MODEM, i != 2);
			rdc(A_MODSTAT, (8'h10 << i) | ((i == 2) ? 8'h00 : (8'h01 << i)));
			rdc(A_MODSTAT, 8'h10 << i);
			check(IRQ_MODEM, 1'b0);
			i_peer.set_pin(i, 1'b1);
			repeat (8) @(posedge CLK);
			rdc(A_MODSTAT, 8'h01 << i);
		end
		// loopback takes status from the control bits and parks the outputs
		wr(A_MODCTL, 8'h05);
		repeat (2) @(posedge CLK);
		check(MODEM_OUT_N, 4'ha);
		wr(A_MODCTL, 8'h1a);
		i_peer.set_pin(3, 1'b0);
		repeat (8) @(posedge CLK);
		check(MODEM_OUT_N, 4'hf);
		bus_xfer(1'b0, A_MODSTAT, 8'h00, 4'h0);
		check(rd & 32'hf0, 32'h90);
		wr(A_MODCTL, 8'h15);
		repeat (8) @(posedge CLK);
		bus_xfer(1'b0, A_MODSTAT, 8'h00, 4'h0);
		check(rd & 32'hf0, 32'h60);
		wr(A_MODCTL, 8'h00);
		i_peer.set_pin(3, 1'b1);
		repeat (8) @(posedge CLK);
		bus_xfer(1'b0, A_MODSTAT, 8'h00, 4'h0);
		// divisor of 1 then 3 against a reference edge every 6 cycles
		wr(A_DIVHI, 8'h00);
		wr(A_DIVLO, 8'h01);
		tick_gap(n);
		check(n, 6);
		wr(A_DIVLO, 8'h03);
		tick_gap(n);
		check(n, 18);
		rdc(A_DIVLO, 8'h03);
		wr(A_DIVHI, 8'h01);
		rdc(A_DIVHI, 8'h01);
		wr(A_DIVHI, 8'h00);
		n = 0;
		while (BAUD_OUT !== 1'b1 && n < 40) begin
			@(posedge CLK);
			n++;
		end
		check(n < 40, 1'b1);
		// character mode, 8 bits without parity
		wr(A_DIVLO, 8'h01);
		wr(A_LINECTL, 8'h03);
		wr(A_IRQEN, 8'h01);
		i_peer.send_frame(8'h5a, 8, 1'b0, 1'b0);
		check(IRQ_RX_AVAIL, 1'b1);
		rdc(A_RXBUF, 8'h5a);
		@(posedge CLK);
		check(IRQ_RX_AVAIL, 1'b0);
		// 5 bits with even parity, good parity then bad
		wr(A_LINECTL, 8'h18);
		for (int p = 1; p >= 0; p--) begin
			i_peer.send_frame(8'hf3, 5, 1'b1, p[0]);
			bus_xfer(1'b0, A_RXSTAT, 8'h00, 4'h0);
			check(rd & 32'h7, {29'h0, !p[0], 2'h1});
			rdc(A_RXBUF, 8'h13);
		end
		// odd parity then mark parity, each sent with a zero parity bit
		for (int k = 0; k < 2; k++) begin
			wr(A_LINECTL, k ? 8'h28 : 8'h08);
			i_peer.send_frame(8'hf3, 5, 1'b1, 1'b0);
			bus_xfer(1'b0, A_RXSTAT, 8'h00, 4'h0);
			check(rd & 32'h7, k ? 32'h5 : 32'h1);
			rdc(A_RXBUF, 8'h13);
		end
		// fifo mode with trigger 8, filled past its depth, then drained in order
		wr(A_LINECTL, 8'h03);
		wr(A_FIFOCTL, 8'h81);
		rdc(A_FIFOCTL, 8'h81);
		for (int i = 0; i < 17; i++) begin
			i_peer.send_frame(i[7:0] + 8'h40, 8, 1'b0, 1'b0);
			check(IRQ_RX_AVAIL, i >= 7);
		end
		bus_xfer(1'b0, A_RXSTAT, 8'h00, 4'h0);
		check(rd & 32'h3, 32'h3);
		for (int i = 0; i < 16; i++) begin
			rdc(A_RXBUF, i[7:0] + 8'h40);
		end
		bus_xfer(1'b0, A_RXSTAT, 8'h00, 4'h0);
		check(rd & 32'h3, 32'h0);
		finish_test();
	end
endmodule
